// *** core/dea_array.sv ***
// 64 x 8 storage held in flip-flops, cleared to RST_DATA by reset
module dea_array
  import dea_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // write port
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // read port
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem_r [DEPTH];
  logic [7:0] mem_nxt [DEPTH];

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++)
    begin : g_cell
      always_comb
      begin
        mem_nxt[gi] = mem_r[gi];
        if (wr_en && (wr_addr == ADDR_W'(gi)))
        begin
          mem_nxt[gi] = wr_data;
        end
      end

      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          mem_r[gi] <= RST_DATA;
        end
        else
        begin
          mem_r[gi] <= mem_nxt[gi];
        end
      end
    end
  endgenerate

  assign rd_data = mem_r[rd_addr];
endmodule

// *** core/dea_pkg.sv ***
// constants, field layout and states of the data eeprom access block
package dea_pkg;
  // apb byte addresses
  localparam logic [7:0] OFF_ADDR = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] OFF_P1L = 8'h08;
  localparam logic [7:0] OFF_P1H = 8'h0C;
  localparam logic [7:0] OFF_P2L = 8'h10;
  localparam logic [7:0] OFF_P2H = 8'h14;
  localparam logic [7:0] OFF_IND1 = 8'h18;
  localparam logic [7:0] OFF_IND2 = 8'h1C;
  localparam logic [7:0] OFF_IRQ = 8'h20;
  // indirect location of the control register
  localparam logic [7:0] CTRL_SECTOR = 8'h01;
  localparam logic [7:0] CTRL_LOW = 8'h3E;
  // control register fields
  localparam int BIT_STORE_EN = 3;
  localparam int BIT_STORE_GO = 2;
  localparam int BIT_FETCH_EN = 1;
  localparam int BIT_FETCH_GO = 0;
  // interrupt register fields
  localparam int BIT_NV_IE = 0;
  localparam int BIT_GIE = 1;
  localparam int BIT_NV_IF = 2;
  // array geometry
  localparam int ADDR_W = 6;
  localparam int DEPTH = 64;
  // reset values
  localparam logic [5:0] RST_ADDR = 6'h00;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_PTR = 8'h00;
  localparam logic [3:0] RST_CTRL = 4'h0;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int READ_TIME_NS = 40;
  localparam int READ_CYCLES = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_TIME_NS = 2000000;
  localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } dea_state_e;
endpackage

// *** core/dea_top.sv ***
// data eeprom access controller with apb register port
// Operation
// - fetch_start write ignored unless fetch_enable already set
// - hardware clears fetch_start at read end; byte then in nv_data_reg
// - fetched byte stays in nv_data_reg until next read or write
// - store_start without store_enable starts no write
// - write cycle length set by an internal timer, not software
// - hardware clears store_start when the write cycle finishes
// - store_enable is clear after reset
// - pointer high bytes reset to zero, hiding the control register
// - write end sets nv_irq_flag; nv_irq_enable gates the interrupt
// - interrupt taken only with both enables set and stack not full
// - servicing the interrupt clears nv_irq_flag
// - control register sits at sector 1 offset 3EH, indirect only
// - control bits: store_enable 3, store_start 2, fetch_enable 1, fetch_start 0
// - address register holds 6 bits; upper bits read zero
//
// Register access over APB and the address map were left to the implementer.
module dea_top
  import dea_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES_P = WRITE_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu interrupt handshake
  input wire logic stack_full,
  input wire logic irq_ack,
  output logic irq_request,
  // status
  output logic nv_busy
);
  function automatic logic is_ctrl(input logic [7:0] hi, input logic [7:0] lo);
    is_ctrl = (hi == CTRL_SECTOR) && (lo == CTRL_LOW);
  endfunction

  // apb group
  logic pready_r;
  logic pready_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  // register group
  logic [5:0] addr_r;
  logic [5:0] addr_nxt;
  logic [7:0] data_r;
  logic [7:0] data_nxt;
  logic [7:0] p1l_r;
  logic [7:0] p1l_nxt;
  logic [7:0] p1h_r;
  logic [7:0] p1h_nxt;
  logic [7:0] p2l_r;
  logic [7:0] p2l_nxt;
  logic [7:0] p2h_r;
  logic [7:0] p2h_nxt;
  logic [3:0] ctrl_r;
  logic [3:0] ctrl_nxt;
  logic ie_r;
  logic ie_nxt;
  logic gie_r;
  logic gie_nxt;
  logic if_r;
  logic if_nxt;
  logic irq_r;
  logic irq_nxt;
  // sequencer group
  dea_state_e state_r;
  dea_state_e state_nxt;
  logic [7:0] rcnt_r;
  logic [7:0] rcnt_nxt;
  logic busy_r;
  logic busy_nxt;

  logic wr_acc;
  logic ctrl_wr;
  logic ctrl_hit1;
  logic ctrl_hit2;
  logic go_store;
  logic go_fetch;
  logic rd_done;
  logic tmr_done;
  logic [7:0] mem_rdata;
  logic [31:0] rd_word;
  logic rd_ok;

  assign wr_acc = psel && penable && pready_r && pwrite;
  assign ctrl_hit1 = is_ctrl(p1h_r, p1l_r);
  assign ctrl_hit2 = is_ctrl(p2h_r, p2l_r);
  assign ctrl_wr = wr_acc && (((paddr == OFF_IND1) && ctrl_hit1)
                   || ((paddr == OFF_IND2) && ctrl_hit2));
  // old enable values decide; nothing starts while busy
  assign go_store = ctrl_wr && (state_r == ST_IDLE) && pwdata[BIT_STORE_GO]
                    && ctrl_r[BIT_STORE_EN];
  assign go_fetch = ctrl_wr && (state_r == ST_IDLE) && pwdata[BIT_FETCH_GO]
                    && ctrl_r[BIT_FETCH_EN] && !go_store;
  assign rd_done = (state_r == ST_READ) && (rcnt_r == 8'h00);

  // read decode
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    case (paddr)
      OFF_ADDR: rd_word = {26'h000_0000, addr_r};
      OFF_DATA: rd_word = {24'h00_0000, data_r};
      OFF_P1L: rd_word = {24'h00_0000, p1l_r};
      OFF_P1H: rd_word = {24'h00_0000, p1h_r};
      OFF_P2L: rd_word = {24'h00_0000, p2l_r};
      OFF_P2H: rd_word = {24'h00_0000, p2h_r};
      OFF_IND1: rd_word = ctrl_hit1 ? {28'h000_0000, ctrl_r} : 32'h0000_0000;
      OFF_IND2: rd_word = ctrl_hit2 ? {28'h000_0000, ctrl_r} : 32'h0000_0000;
      OFF_IRQ: rd_word = {29'h0000_0000, if_r, gie_r, ie_r};
      default: rd_ok = 1'b0;
    endcase
  end

  // apb handshake: one wait state
  always_comb
  begin
    pready_nxt = psel && penable && !pready_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    if (psel && penable && !pready_r)
    begin
      prdata_nxt = pwrite ? 32'h0000_0000 : rd_word;
      pslverr_nxt = !rd_ok;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= pready_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // software-visible registers
  always_comb
  begin
    addr_nxt = addr_r;
    data_nxt = data_r;
    p1l_nxt = p1l_r;
    p1h_nxt = p1h_r;
    p2l_nxt = p2l_r;
    p2h_nxt = p2h_r;
    ctrl_nxt = ctrl_r;
    ie_nxt = ie_r;
    gie_nxt = gie_r;
    if_nxt = if_r;
    if (wr_acc)
    begin
      case (paddr)
        OFF_ADDR: addr_nxt = pwdata[5:0];
        OFF_DATA: data_nxt = pwdata[7:0];
        OFF_P1L: p1l_nxt = pwdata[7:0];
        OFF_P1H: p1h_nxt = pwdata[7:0];
        OFF_P2L: p2l_nxt = pwdata[7:0];
        OFF_P2H: p2h_nxt = pwdata[7:0];
        OFF_IRQ:
        begin
          ie_nxt = pwdata[BIT_NV_IE];
          gie_nxt = pwdata[BIT_GIE];
          if (!pwdata[BIT_NV_IF])
          begin
            if_nxt = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (ctrl_wr)
    begin
      ctrl_nxt[BIT_STORE_EN] = pwdata[BIT_STORE_EN];
      ctrl_nxt[BIT_FETCH_EN] = pwdata[BIT_FETCH_EN];
    end
    if (go_store)
    begin
      ctrl_nxt[BIT_STORE_GO] = 1'b1;
    end
    if (go_fetch)
    begin
      ctrl_nxt[BIT_FETCH_GO] = 1'b1;
    end
    if (irq_ack)
    begin
      if_nxt = 1'b0;
    end
    if (rd_done)
    begin
      ctrl_nxt[BIT_FETCH_GO] = 1'b0;
      data_nxt = mem_rdata;
    end
    if (tmr_done)
    begin
      ctrl_nxt[BIT_STORE_GO] = 1'b0;
      if_nxt = 1'b1;
    end
    irq_nxt = if_r && ie_r && gie_r && !stack_full;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      addr_r <= RST_ADDR;
      data_r <= RST_DATA;
      p1l_r <= RST_PTR;
      p1h_r <= RST_PTR;
      p2l_r <= RST_PTR;
      p2h_r <= RST_PTR;
      ctrl_r <= RST_CTRL;
      ie_r <= 1'b0;
      gie_r <= 1'b0;
      if_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      p1l_r <= p1l_nxt;
      p1h_r <= p1h_nxt;
      p2l_r <= p2l_nxt;
      p2h_r <= p2h_nxt;
      ctrl_r <= ctrl_nxt;
      ie_r <= ie_nxt;
      gie_r <= gie_nxt;
      if_r <= if_nxt;
      irq_r <= irq_nxt;
    end
  end

  // cycle sequencer
  always_comb
  begin
    state_nxt = state_r;
    rcnt_nxt = rcnt_r;
    case (state_r)
      ST_IDLE:
      begin
        if (go_store)
        begin
          state_nxt = ST_WRITE;
        end
        else if (go_fetch)
        begin
          state_nxt = ST_READ;
          rcnt_nxt = 8'(READ_CYCLES - 1);
        end
      end
      ST_READ:
      begin
        if (rcnt_r == 8'h00)
        begin
          state_nxt = ST_IDLE;
        end
        else
        begin
          rcnt_nxt = rcnt_r - 8'h01;
        end
      end
      ST_WRITE:
      begin
        if (tmr_done)
        begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    busy_nxt = (state_nxt != ST_IDLE);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= ST_IDLE;
      rcnt_r <= 8'h00;
      busy_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      rcnt_r <= rcnt_nxt;
      busy_r <= busy_nxt;
    end
  end

  dea_wtimer #(
    .CYCLES(WRITE_CYCLES_P)
  ) u_wtimer (
    .clk(clk),
    .rstn(rstn),
    .start(go_store),
    .busy(),
    .done(tmr_done)
  );

  dea_array u_array (
    .clk(clk),
    .rstn(rstn),
    .wr_en(tmr_done),
    .wr_addr(addr_r),
    .wr_data(data_r),
    .rd_addr(addr_r),
    .rd_data(mem_rdata)
  );

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq_request = irq_r;
  assign nv_busy = busy_r;
endmodule

// *** core/dea_wtimer.sv ***
// write-cycle timer, free of any software clock setting
module dea_wtimer
  import dea_pkg::*;
#(
  parameter int unsigned CYCLES = WRITE_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic start,
  output logic busy,
  output logic done
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic busy_r;
  logic busy_nxt;
  logic done_r;
  logic done_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    if (!busy_r && start)
    begin
      busy_nxt = 1'b1;
      cnt_nxt = 32'(CYCLES) - 32'h0000_0001;
    end
    else if (busy_r)
    begin
      if (cnt_r == 32'h0000_0000)
      begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_r <= 32'h0000_0000;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign busy = busy_r;
  assign done = done_r;
endmodule

// *** testbench/dea_top_props.sv ***
// assertion checker for the data eeprom access block
module dea_top_chk
  import dea_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES_P = WRITE_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // interrupt and status
  input wire logic stack_full,
  input wire logic irq_ack,
  input wire logic irq_request,
  input wire logic nv_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  int unsigned busy_cnt;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      busy_cnt <= 0;
    else
      busy_cnt <= nv_busy ? busy_cnt + 1 : 0;
  chk_ready_one_wait:
    assert property (psel && penable && !pready |=> pready) else $error("late ready");
  chk_ready_pulse:
    assert property (pready |=> !pready) else $error("ready too long");
  chk_err_with_ready:
    assert property (pslverr |-> pready && prdata == 0) else $error("bad error answer");
  chk_irq_stack_block:
    assert property (stack_full |=> !irq_request) else $error("irq with full stack");
  chk_irq_ack_clear:
    assert property (irq_ack && !nv_busy |=> ##1 !irq_request) else $error("flag kept");
  chk_irq_cause:
    assert property ($rose(irq_request) |-> $past(nv_busy, 2) || ($past(pready, 2) &&
      $past(pwrite, 2)) || $past(stack_full) || $past(stack_full, 2)) else $error("stray irq");
  chk_read_len:
    assert property ($rose(nv_busy) |-> nv_busy [*4]) else $error("cycle too short");
  chk_write_bound:
    assert property (nv_busy |-> busy_cnt <= WRITE_CYCLES_P + 1) else $error("cycle too long");
endmodule

bind dea_top dea_top_chk #(.WRITE_CYCLES_P(WRITE_CYCLES_P)) u_chk (.clk(clk), .rstn(rstn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .stack_full(stack_full),
  .irq_ack(irq_ack), .irq_request(irq_request), .nv_busy(nv_busy));

// *** testbench/dea_top_tb.sv ***
// self-checking bench for the data eeprom access block
module dea_top_tb;
  import dea_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, psel, penable, pwrite, stack_full, irq_ack;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, irq_request, nv_busy;
  logic [33:0] notes[$];
  logic [7:0] rst_offs[6] = '{OFF_ADDR, OFF_DATA, OFF_P1H, OFF_P2H, OFF_IND1, OFF_IRQ};
  int num_errors = 0;
  int checks = 0;
  logic [5:0] ea;
  logic [7:0] ed;
  dea_top #(.WRITE_CYCLES_P(20)) uut (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stack_full(stack_full), .irq_ack(irq_ack),
    .irq_request(irq_request), .nv_busy(nv_busy));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic final_report();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; the expected answer goes to the queue
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic ck = 1'b0, input logic [31:0] exp = 32'h0, input logic err = 1'b0);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    notes.push_back({ck, err, exp});
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 1'b1, exp);
  endtask
  task automatic wait_idle();
    @(negedge clk);
    while (nv_busy !== 1'b0)
      @(negedge clk);
  endtask
  // answer watcher
  always @(negedge clk)
    if (psel && penable && pready === 1'b1 && notes.size() > 0)
    begin
      if (notes[0][33])
        cmp(prdata, notes[0][31:0]);
      cmp({31'h0, pslverr}, {31'h0, notes[0][32]});
      void'(notes.pop_front());
    end
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    final_report();
  end
  initial
  begin
    {rstn, psel, penable, pwrite, stack_full, irq_ack, paddr, pwdata} = '0;
    void'($urandom(32'h0369_2aa1));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    foreach (rst_offs[i])
      rd(rst_offs[i], 32'h0);
    apb(1'b0, 8'h24, 32'h0, 1'b1, 32'h0, 1'b1);
    apb(1'b1, 8'hFC, 32'h0, 1'b0, 32'h0, 1'b1);
    wr(OFF_P1L, {24'h0, CTRL_LOW});
    wr(OFF_P1H, {24'h0, CTRL_SECTOR});
    rd(OFF_IND1, 32'h0);
    wr(OFF_IND1, 32'h0000_00F1);
    rd(OFF_IND1, 32'h0);
    wr(OFF_IND1, 32'h0000_00F4);
    rd(OFF_IND1, 32'h0);
    $display("test protect done");
    repeat (3)
    begin
      {ea, ed} = 14'($urandom());
      wr(OFF_ADDR, {26'($urandom()), ea});
      rd(OFF_ADDR, {26'h0, ea});
      wr(OFF_DATA, {24'h0, ed});
      wr(OFF_IRQ, 32'h0);
      wr(OFF_IND1, 32'h0000_0008);
      wr(OFF_IND1, 32'h0000_000C);
      rd(OFF_IND1, 32'h0000_000C);
      wr(OFF_IRQ, 32'h0000_0002);
      wait_idle();
      rd(OFF_IND1, 32'h0000_0008);
      rd(OFF_IRQ, 32'h0000_0006);
      wr(OFF_IND1, 32'h0000_0002);
      wr(OFF_DATA, 32'h0);
      wr(OFF_IND1, 32'h0000_0003);
      wait_idle();
      rd(OFF_IND1, 32'h0000_0002);
      rd(OFF_DATA, {24'h0, ed});
      rd(OFF_DATA, {24'h0, ed});
    end
    $display("test store fetch done");
    wr(OFF_IRQ, 32'h0000_0007);
    repeat (3) @(negedge clk);
    cmp({31'h0, irq_request}, 32'h1);
    @(posedge clk);
    stack_full <= 1'b1;
    repeat (2) @(negedge clk);
    cmp({31'h0, irq_request}, 32'h0);
    @(posedge clk);
    stack_full <= 1'b0;
    irq_ack <= 1'b1;
    @(posedge clk);
    irq_ack <= 1'b0;
    repeat (2) @(negedge clk);
    cmp({31'h0, irq_request}, 32'h0);
    rd(OFF_IRQ, 32'h0000_0003);
    $display("test interrupt done");
    repeat (3) @(posedge clk);
    final_report();
  end
endmodule
